// ### verilog/setm_top.sv
// state event timer: split or unified counter, events, actions, apb slave
// assumes apb3 master on pclk; in_pins asynchronous to pclk
`timescale 1ns/1ps
`include "setm_cfg.svh"
// Behaviour
// - unified mode runs only on low halt bit
// - compare event fires on selected match equality
// - events fire only in enabled states
// - state-change event loads next state
// - set mask event drives output high
// - clear mask event drives output low
// - toggle event inverts output level
// - limit resets count or reverses direction
// - stop event stops counting, events continue
// - start event resumes a stopped counter
// - halt event halts counter, suppresses its events
// - only software clears a halt
// - dma mask event raises dma request
// - capture event copies counter into register
// - split targets selected half; unified uses low
// - enabled event raises interrupt, sets flag
// - io condition optional; ignored for match-only
// - per-output conflict resolution on set+clear
// - config write while running flags bus error
module setm_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [`SETM_NIN-1:0] in_pins,
	output logic [`SETM_NOUT-1:0] out_pins,
	output logic [`SETM_NDMA-1:0] dma_req,
	output logic irq
);
	import setm_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic unify_reg, bidir_l_reg, bidir_h_reg;
	logic stop_l_reg, halt_l_reg, down_l_reg;
	logic stop_h_reg, halt_h_reg, down_h_reg;
	logic [15:0] cnt_l_reg, cnt_h_reg;
	logic [1:0] state_reg;
	logic [`SETM_NIN-1:0] in_s1_reg, in_s2_reg, in_prev_reg;
	logic [`SETM_NOUT-1:0] out_prev_reg, out_q;
	logic [15:0] res_reg, lim_reg, haltm_reg, stopm_reg, startm_reg;
	logic [`SETM_NEV-1:0] flag_reg, inten_reg, mode_reg;
	logic [1:0] err_reg;
	logic [`SETM_NDMA-1:0] dma_reg;
	logic [31:0] prdata_reg;
	logic [`SETM_NEV-1:0] dmam_reg [`SETM_NDMA];
	logic [31:0] mv_reg [`SETM_NMR];
	logic [8:0] cap_reg [`SETM_NMR];
	logic [3:0] ev_sm_reg [`SETM_NEV];
	logic [`SETM_EC_W-1:0] ev_ct_reg [`SETM_NEV];
	logic [`SETM_NEV-1:0] set_reg [`SETM_NOUT];
	logic [`SETM_NEV-1:0] clr_reg [`SETM_NOUT];
	logic [`SETM_NEV-1:0] fire;
	logic [`SETM_NMR-1:0] meq_l, meq_h, cap_hit;
	logic [`SETM_NOUT-1:0] set_hit, clr_hit;
	logic [`SETM_NDMA-1:0] dma_hit;
	logic ld_any;
	logic [1:0] ld_st;

	// apb decode, zero wait states
	wire [11:0] a = paddr;
	wire wr = psel & penable & pwrite;
	wire rd_setup = psel & ~penable;
	wire s_cfg = a == `SETM_A_CFG;
	wire s_ctrl = a == `SETM_A_CTRL;
	wire s_cnt = a == `SETM_A_CNT;
	wire s_st = a == `SETM_A_STATE;
	wire s_in = a == `SETM_A_INPUT;
	wire s_out = a == `SETM_A_OUTPUT;
	wire s_res = a == `SETM_A_RES;
	wire s_flag = a == `SETM_A_FLAG;
	wire s_ien = a == `SETM_A_INTEN;
	wire s_err = a == `SETM_A_ERR;
	wire s_mode = a == `SETM_A_MODE;
	wire s_lim = a == `SETM_A_LIM;
	wire s_hlt = a == `SETM_A_HALT;
	wire s_stp = a == `SETM_A_STOP;
	wire s_sta = a == `SETM_A_START;
	wire s_dma = (a & `SETM_M_DMA) == `SETM_A_DMA;
	wire s_mv = (a & `SETM_M_MV) == `SETM_A_MV;
	wire s_cap = (a & `SETM_M_MV) == `SETM_A_CAP;
	wire s_ev = (a & `SETM_M_EV) == `SETM_A_EV;
	wire s_om = (a & `SETM_M_EV) == `SETM_A_OUTM;
	wire aligned = a[1:0] == 2'b00;
	wire mapped = aligned & (s_cfg | s_ctrl | s_cnt | s_st | s_in | s_out | s_res
		| s_flag | s_ien | s_err | s_mode | s_lim | s_hlt | s_stp | s_sta
		| s_dma | s_mv | s_cap | s_ev | s_om);
	wire [2:0] ri = a[4:2];
	wire [2:0] ei = a[5:3];

	// writes to config or count while running are refused
	wire cfg_w = wr & mapped & (s_cfg | s_cnt);
	wire err_l_w = cfg_w & ~halt_l_reg;
	wire err_h_w = cfg_w & ~unify_reg & ~halt_h_reg;
	wire refuse = err_l_w | err_h_w;
	wire w_ok = wr & mapped & ~refuse;
	wire cnt_wr = w_ok & s_cnt;
	wire ctrl_wr = w_ok & s_ctrl;
	assign pready = 1'b1;
	assign pslverr = psel & penable & (~mapped | refuse);

	// input synchroniser and edge history
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			in_s1_reg <= '0;
			in_s2_reg <= '0;
			in_prev_reg <= '0;
			out_prev_reg <= '0;
		end
		else
		begin
			in_s1_reg <= in_pins;
			in_s2_reg <= in_s1_reg;
			in_prev_reg <= in_s2_reg;
			out_prev_reg <= out_q;
		end
	end

	// match compare and capture per pool register
	wire [31:0] c32 = {cnt_h_reg, cnt_l_reg};
	genvar gi;
	generate
		for (gi = 0; gi < `SETM_NMR; gi++)
		begin : g_mr
			wire [31:0] capv = unify_reg ? c32 : cap_reg[gi][`SETM_CP_HI] ?
				{16'h0000, cnt_h_reg} : {16'h0000, cnt_l_reg};
			assign meq_l[gi] = ~mode_reg[gi] & (unify_reg ? (c32 == mv_reg[gi]) :
				(cnt_l_reg == mv_reg[gi][15:0]));
			assign meq_h[gi] = ~mode_reg[gi] & (cnt_h_reg == mv_reg[gi][31:16]);
			assign cap_hit[gi] = mode_reg[gi] & |(fire & cap_reg[gi][7:0]);
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					mv_reg[gi] <= 32'h00000000;
				else if (cap_hit[gi])
					mv_reg[gi] <= capv;
				else if (w_ok && s_mv && ri == 3'(gi))
					mv_reg[gi] <= pwdata;
			end
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					cap_reg[gi] <= 9'h000;
				else if (w_ok && s_cap && ri == 3'(gi))
					cap_reg[gi] <= pwdata[8:0];
			end
			a_capture: assert property (cap_hit[gi] |=> mv_reg[gi] == $past(capv))
				else $error("capture did not store counter");
			a_cap_pool: assert property (mode_reg[gi] |-> !meq_l[gi] && !meq_h[gi])
				else $error("capture register took part in compare");
		end
	endgenerate

	// event detectors and their per-event registers
	generate
		for (gi = 0; gi < `SETM_NEV; gi++)
		begin : g_ev
			setm_evt u_evt (
				.pclk(pclk),
				.presetn(presetn),
				.smask(ev_sm_reg[gi]),
				.ctrl(ev_ct_reg[gi]),
				.cur_state(state_reg),
				.meq_l(meq_l),
				.meq_h(meq_h),
				.unify(unify_reg),
				.halt_l(halt_l_reg),
				.halt_h(halt_h_reg),
				.io_lvl({out_q, in_s2_reg}),
				.io_prev({out_prev_reg, in_prev_reg}),
				.fire(fire[gi])
			);
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					ev_sm_reg[gi] <= 4'h0;
					ev_ct_reg[gi] <= '0;
				end
				else if (w_ok && s_ev && ei == 3'(gi))
				begin
					if (a[2])
						ev_ct_reg[gi] <= pwdata[`SETM_EC_W-1:0];
					else
						ev_sm_reg[gi] <= pwdata[3:0];
				end
			end
		end
	endgenerate

	// output pins with set/clear masks
	generate
		for (gi = 0; gi < `SETM_NOUT; gi++)
		begin : g_out
			assign set_hit[gi] = |(fire & set_reg[gi]);
			assign clr_hit[gi] = |(fire & clr_reg[gi]);
			setm_out u_out (
				.pclk(pclk),
				.presetn(presetn),
				.set_hit(set_hit[gi]),
				.clr_hit(clr_hit[gi]),
				.res(setm_res_t'(res_reg[2*gi+1 -: 2])),
				.wr_en(w_ok & s_out),
				.wr_val(pwdata[gi]),
				.q(out_q[gi])
			);
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					set_reg[gi] <= '0;
					clr_reg[gi] <= '0;
				end
				else if (w_ok && s_om && ei == 3'(gi))
				begin
					if (a[2])
						clr_reg[gi] <= pwdata[`SETM_NEV-1:0];
					else
						set_reg[gi] <= pwdata[`SETM_NEV-1:0];
				end
			end
		end
	endgenerate
	assign out_pins = out_q;

	// dma request masks and pulses
	generate
		for (gi = 0; gi < `SETM_NDMA; gi++)
		begin : g_dma
			assign dma_hit[gi] = |(fire & dmam_reg[gi]);
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					dmam_reg[gi] <= '0;
				else if (w_ok && s_dma && a[2] == 1'(gi))
					dmam_reg[gi] <= pwdata[`SETM_NEV-1:0];
			end
		end
	endgenerate

	// counter actions; high masks ignored in unified mode
	wire lim_l = |(fire & lim_reg[7:0]);
	wire stp_l = |(fire & stopm_reg[7:0]);
	wire sta_l = |(fire & startm_reg[7:0]);
	wire hlt_l = |(fire & haltm_reg[7:0]);
	wire lim_h = ~unify_reg & |(fire & lim_reg[15:8]);
	wire stp_h = ~unify_reg & |(fire & stopm_reg[15:8]);
	wire sta_h = ~unify_reg & |(fire & startm_reg[15:8]);
	wire hlt_h = ~unify_reg & |(fire & haltm_reg[15:8]);

	// low (or unified) counter step; only the low halt gates it when unified
	wire run_l = ~halt_l_reg & ~stop_l_reg;
	wire run_h = ~unify_reg & ~halt_h_reg & ~stop_h_reg;
	wire [31:0] l_cur = unify_reg ? c32 : {16'h0000, cnt_l_reg};
	wire dn_l_nx = bidir_l_reg & (lim_l ? ~down_l_reg :
		(down_l_reg & (l_cur != 32'h00000000)));
	wire [31:0] l_step = (lim_l & ~bidir_l_reg) ? 32'h00000000 :
		dn_l_nx ? (l_cur - 32'h00000001) : (l_cur + 32'h00000001);
	wire dn_h_nx = bidir_h_reg & (lim_h ? ~down_h_reg :
		(down_h_reg & (cnt_h_reg != 16'h0000)));
	wire [15:0] h_step = (lim_h & ~bidir_h_reg) ? 16'h0000 :
		dn_h_nx ? (cnt_h_reg - 16'h0001) : (cnt_h_reg + 16'h0001);
	wire [15:0] cnt_l_next = cnt_wr ? pwdata[15:0] : run_l ? l_step[15:0] : cnt_l_reg;
	wire [15:0] cnt_h_next = cnt_wr ? pwdata[31:16] :
		unify_reg ? (run_l ? l_step[31:16] : cnt_h_reg) :
		run_h ? h_step : cnt_h_reg;

	// stop and halt control: events set, software clears, set wins
	wire stop_l_next = stp_l | (ctrl_wr ? pwdata[`SETM_CT_STPL] : (stop_l_reg & ~sta_l));
	wire halt_l_next = hlt_l | (ctrl_wr ? pwdata[`SETM_CT_HLTL] : halt_l_reg);
	wire stop_h_next = stp_h | (ctrl_wr ? pwdata[`SETM_CT_STPH] : (stop_h_reg & ~sta_h));
	wire halt_h_next = hlt_h | (ctrl_wr ? pwdata[`SETM_CT_HLTH] : halt_h_reg);

	// counter and control flops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_l_reg <= 16'h0000;
			cnt_h_reg <= 16'h0000;
			down_l_reg <= 1'b0;
			down_h_reg <= 1'b0;
			stop_l_reg <= 1'b0;
			stop_h_reg <= 1'b0;
			halt_l_reg <= `SETM_RST_HALT;
			halt_h_reg <= `SETM_RST_HALT;
		end
		else
		begin
			cnt_l_reg <= cnt_l_next;
			cnt_h_reg <= cnt_h_next;
			down_l_reg <= run_l ? dn_l_nx : down_l_reg;
			down_h_reg <= run_h ? dn_h_nx : down_h_reg;
			stop_l_reg <= stop_l_next;
			stop_h_reg <= stop_h_next;
			halt_l_reg <= halt_l_next;
			halt_h_reg <= halt_h_next;
		end
	end

	// state load, highest-numbered firing event wins
	always_comb
	begin
		ld_any = 1'b0;
		ld_st = state_reg;
		for (int i = 0; i < `SETM_NEV; i++)
			if (fire[i] && ev_ct_reg[i][`SETM_EC_STLD])
			begin
				ld_any = 1'b1;
				ld_st = ev_ct_reg[i][`SETM_EC_NXT];
			end
	end

	// plain configuration and status registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			{unify_reg, bidir_l_reg, bidir_h_reg} <= 3'h0;
			state_reg <= 2'h0;
			{res_reg, lim_reg, haltm_reg, stopm_reg, startm_reg} <= '0;
			{inten_reg, mode_reg, flag_reg} <= '0;
			err_reg <= 2'h0;
			dma_reg <= '0;
		end
		else
		begin
			if (w_ok && s_cfg)
				{bidir_h_reg, bidir_l_reg, unify_reg} <= pwdata[`SETM_CF_BDH:`SETM_CF_UNI];
			state_reg <= ld_any ? ld_st : (w_ok && s_st) ? pwdata[1:0] : state_reg;
			if (w_ok && s_res) res_reg <= pwdata[15:0];
			if (w_ok && s_lim) lim_reg <= pwdata[15:0];
			if (w_ok && s_hlt) haltm_reg <= pwdata[15:0];
			if (w_ok && s_stp) stopm_reg <= pwdata[15:0];
			if (w_ok && s_sta) startm_reg <= pwdata[15:0];
			if (w_ok && s_ien) inten_reg <= pwdata[`SETM_NEV-1:0];
			if (w_ok && s_mode) mode_reg <= pwdata[`SETM_NEV-1:0];
			// write-one-to-clear, new events win
			flag_reg <= (flag_reg & ~((w_ok && s_flag) ? pwdata[`SETM_NEV-1:0] :
				'0)) | fire;
			err_reg <= (err_reg & ~((wr && mapped && s_err) ? pwdata[1:0] : 2'h0))
				| {err_h_w, err_l_w};
			dma_reg <= dma_hit;
		end
	end
	assign dma_req = dma_reg;
	assign irq = |(flag_reg & inten_reg);

	// read selection, sampled in the setup cycle
	wire [31:0] ctrl_rd = {13'h0000, down_h_reg, halt_h_reg, stop_h_reg,
		13'h0000, down_l_reg, halt_l_reg, stop_l_reg};
	wire [31:0] rd_val = !mapped ? 32'h00000000 :
		s_cfg ? {29'h00000000, bidir_h_reg, bidir_l_reg, unify_reg} :
		s_ctrl ? ctrl_rd :
		s_cnt ? c32 :
		s_st ? {30'h00000000, state_reg} :
		s_in ? {24'h000000, in_s2_reg} :
		s_out ? {24'h000000, out_q} :
		s_res ? {16'h0000, res_reg} :
		s_flag ? {24'h000000, flag_reg} :
		s_ien ? {24'h000000, inten_reg} :
		s_err ? {30'h00000000, err_reg} :
		s_mode ? {24'h000000, mode_reg} :
		s_lim ? {16'h0000, lim_reg} :
		s_hlt ? {16'h0000, haltm_reg} :
		s_stp ? {16'h0000, stopm_reg} :
		s_sta ? {16'h0000, startm_reg} :
		s_dma ? {24'h000000, dmam_reg[a[2]]} :
		s_mv ? mv_reg[ri] :
		s_cap ? {23'h000000, cap_reg[ri]} :
		s_ev ? (a[2] ? {17'h00000, ev_ct_reg[ei]} : {28'h0000000, ev_sm_reg[ei]}) :
		(a[2] ? {24'h000000, clr_reg[ei]} : {24'h000000, set_reg[ei]});
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_reg <= 32'h00000000;
		else if (rd_setup)
			prdata_reg <= rd_val;
	end
	assign prdata = prdata_reg;

	a_unify_halt: assert property (unify_reg && halt_l_reg && !cnt_wr |=> $stable(c32))
		else $error("unified counter moved while low half halted");
	a_unify_run: assert property (unify_reg && !halt_l_reg && !stop_l_reg && !lim_l
		&& !bidir_l_reg && !cnt_wr |=> c32 == $past(c32) + 32'h00000001)
		else $error("unified counter did not count");
	a_state_load: assert property (ld_any |=> state_reg == $past(ld_st))
		else $error("state not loaded on event");
	a_limit_reset: assert property (lim_l && run_l && !bidir_l_reg && !cnt_wr
		|=> cnt_l_reg == 16'h0000)
		else $error("limit did not reset counter");
	a_stop_hold: assert property (stp_l && !cnt_wr |=> stop_l_reg ##1 $stable(cnt_l_reg)
		|| cnt_wr || halt_l_reg || !stop_l_reg)
		else $error("stop event did not stop counter");
	a_start_run: assert property (sta_l && !stp_l && !ctrl_wr |=> !stop_l_reg)
		else $error("start event did not resume counter");
	a_halt_keep: assert property (halt_l_reg && !ctrl_wr |=> halt_l_reg)
		else $error("halt released without software");
	a_dma_req: assert property (dma_hit[0] |=> dma_req[0])
		else $error("dma request missing");
	a_irq_flag: assert property (|(fire & inten_reg) |=> irq && |(flag_reg & inten_reg))
		else $error("interrupt not raised for event");
	a_bus_err: assert property (err_l_w |=> err_reg[0] && $stable(unify_reg))
		else $error("running write not flagged");
	c_state_chg: cover property (ld_any ##1 state_reg != $past(state_reg));
	c_capture: cover property (|cap_hit);
	c_dma: cover property (|dma_req);
	c_halt: cover property (hlt_l ##1 halt_l_reg);
endmodule // setm_top

// ### common/setm_cfg.svh
// offsets, field positions and reset values of the state event timer
// assumes inclusion by bare name from the design files
`ifndef SETM_CFG_SVH
`define SETM_CFG_SVH
// sizes
`define SETM_NEV 8
`define SETM_NMR 8
`define SETM_NIN 8
`define SETM_NOUT 8
`define SETM_NDMA 2
// register byte offsets
`define SETM_A_CFG 12'h000
`define SETM_A_CTRL 12'h004
`define SETM_A_CNT 12'h008
`define SETM_A_STATE 12'h00c
`define SETM_A_INPUT 12'h010
`define SETM_A_OUTPUT 12'h014
`define SETM_A_RES 12'h018
`define SETM_A_FLAG 12'h01c
`define SETM_A_INTEN 12'h020
`define SETM_A_ERR 12'h024
`define SETM_A_DMA 12'h028
`define SETM_A_MODE 12'h030
`define SETM_A_LIM 12'h034
`define SETM_A_HALT 12'h038
`define SETM_A_STOP 12'h03c
`define SETM_A_START 12'h040
`define SETM_A_MV 12'h100
`define SETM_A_CAP 12'h140
`define SETM_A_EV 12'h200
`define SETM_A_OUTM 12'h300
// region masks
`define SETM_M_WORD 12'hffc
`define SETM_M_DMA 12'hff8
`define SETM_M_MV 12'hfe0
`define SETM_M_EV 12'hfc0
// config fields
`define SETM_CF_UNI 0
`define SETM_CF_BDL 1
`define SETM_CF_BDH 2
// control fields
`define SETM_CT_STPL 0
`define SETM_CT_HLTL 1
`define SETM_CT_DNL 2
`define SETM_CT_STPH 16
`define SETM_CT_HLTH 17
`define SETM_CT_DNH 18
`define SETM_RST_HALT 1'b1
// event control fields
`define SETM_EC_MSEL 2:0
`define SETM_EC_HEV 3
`define SETM_EC_IOSEL 6:4
`define SETM_EC_IOOUT 7
`define SETM_EC_COND 9:8
`define SETM_EC_CMB 11:10
`define SETM_EC_STLD 12
`define SETM_EC_NXT 14:13
`define SETM_EC_W 15
// capture control high-half select
`define SETM_CP_HI 8
`endif

// ### common/setm_pkg.sv
// types shared by the state event timer modules
// assumes nothing beyond a SystemVerilog compiler
package setm_pkg;
	// how match and io condition combine
	typedef enum logic [1:0] {cmb_or, cmb_match, cmb_io, cmb_and} setm_cmb_t;
	// output set/clear conflict resolution
	typedef enum logic [1:0] {res_none, res_set, res_clr, res_tgl} setm_res_t;
	// io condition
	typedef enum logic [1:0] {cnd_low, cnd_rise, cnd_fall, cnd_high} setm_cnd_t;
endpackage

// ### verilog/setm_evt.sv
// one event detector: match/io qualification, state gating, halt gating
// assumes synchronised io levels and previous levels from the parent
`timescale 1ns/1ps
`include "setm_cfg.svh"
module setm_evt (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] smask,
	input wire logic [`SETM_EC_W-1:0] ctrl,
	input wire logic [1:0] cur_state,
	input wire logic [`SETM_NMR-1:0] meq_l,
	input wire logic [`SETM_NMR-1:0] meq_h,
	input wire logic unify,
	input wire logic halt_l,
	input wire logic halt_h,
	input wire logic [15:0] io_lvl,
	input wire logic [15:0] io_prev,
	output logic fire
);
	import setm_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// counter half selection, ignored in unified mode
	wire hsel = ctrl[`SETM_EC_HEV] & ~unify;
	wire [3:0] idx = {ctrl[`SETM_EC_IOOUT], ctrl[`SETM_EC_IOSEL]};
	wire meq = hsel ? meq_h[ctrl[`SETM_EC_MSEL]] : meq_l[ctrl[`SETM_EC_MSEL]];
	wire lvl = io_lvl[idx];
	wire prv = io_prev[idx];
	wire setm_cnd_t cnd = setm_cnd_t'(ctrl[`SETM_EC_COND]);
	wire setm_cmb_t cmb = setm_cmb_t'(ctrl[`SETM_EC_CMB]);
	logic iohit;

	// io condition decode
	always_comb
	begin
		unique case (cnd)
			cnd_low: iohit = ~lvl;
			cnd_rise: iohit = lvl & ~prv;
			cnd_fall: iohit = ~lvl & prv;
			cnd_high: iohit = lvl;
		endcase
	end

	// combine, then gate by state enable and halt
	wire cond = (cmb == cmb_match) ? meq :
		(cmb == cmb_io) ? iohit :
		(cmb == cmb_and) ? (meq & iohit) : (meq | iohit);
	wire halted = hsel ? halt_h : halt_l;
	assign fire = smask[cur_state] & ~halted & cond;

	a_state_gate: assert property (fire |-> smask[cur_state])
		else $error("event fired in a disabled state");
	a_halt_quiet: assert property (halted |-> !fire)
		else $error("event fired on a halted counter");
	a_match_only: assert property ((cmb == cmb_match) && fire |-> meq)
		else $error("match event fired without equality");
	a_io_ignored: assert property ((cmb == cmb_match) && meq && smask[cur_state]
		&& !halted |-> fire)
		else $error("match-only event depended on io");
endmodule // setm_evt

// ### verilog/setm_out.sv
// one output pin flop with set/clear/conflict handling and software write
// assumes hit signals computed on the same clock
`timescale 1ns/1ps
module setm_out (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic set_hit,
	input wire logic clr_hit,
	input wire setm_pkg::setm_res_t res,
	input wire logic wr_en,
	input wire logic wr_val,
	output logic q
);
	import setm_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic q_reg;
	logic q_next;
	logic res_val;

	// conflict resolution value
	always_comb
	begin
		unique case (res)
			res_none: res_val = q_reg;
			res_set: res_val = 1'b1;
			res_clr: res_val = 1'b0;
			res_tgl: res_val = ~q_reg;
		endcase
	end

	// events win over a software write
	assign q_next = (set_hit & clr_hit) ? res_val :
		set_hit ? 1'b1 :
		clr_hit ? 1'b0 :
		wr_en ? wr_val : q_reg;

	// output flop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q_reg <= 1'b0;
		else
			q_reg <= q_next;
	end
	assign q = q_reg;

	a_out_set: assert property (set_hit && !clr_hit |=> q_reg)
		else $error("set event did not raise output");
	a_out_clr: assert property (clr_hit && !set_hit |=> !q_reg)
		else $error("clear event did not lower output");
	a_out_tgl: assert property (set_hit && clr_hit && res == res_tgl
		|=> q_reg != $past(q_reg))
		else $error("toggle did not invert output");
	a_out_keep: assert property (set_hit && clr_hit && res == res_none
		|=> $stable(q_reg))
		else $error("no-change conflict altered output");
endmodule // setm_out

// ### sim/setm_top_tb.sv
// self-checking bench for the state event timer: apb master, random pins, register model
// assumes the design's register map, zero-wait apb and one-cycle event actions
`timescale 1ns/1ps
`include "setm_cfg.svh"
module setm_top_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, v;
	logic [7:0] in_pins, out_pins;
	logic [1:0] dma_req;
	logic [31:0] mdl [int];
	logic [31:0] seed = 32'h02d48446;
	int failures = 0;
	int checks_done = 0;
	int n;

	setm_top u_dut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.in_pins(in_pins),
		.out_pins(out_pins),
		.dma_req(dma_req),
		.irq(irq)
	);

	// free-running 200 mhz clock
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// xorshift source for match value and pin noise
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// pins wander; no event below listens to them
	always @(posedge pclk)
		in_pins <= 8'(rnd());

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one apb transfer; waits for pready, model follows accepted writes
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			failures++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (w && err === 1'b0)
			mdl[a] = d;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdm(input string nm, input logic [11:0] a);
		apb(1'b0, a, 32'h0);
		chk(nm, mdl[a], rd);
	endtask

	task automatic print_verdict();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// hang guard
	initial
	begin
		repeat (10000) @(posedge pclk);
		failures++;
		print_verdict();
	end

	// main sequence
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		v = 32'h10 + (rnd() % 32'h40);
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		// reset value and an unmapped word
		apb(1'b0, `SETM_A_CTRL, 32'h0);
		chk("ctrl reset", 32'h00020002, rd);
		apb(1'b0, 12'hff4, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, rd);
		// unified counter; event 0 on match reg 0 sets out 0, loads state 1, raises dma and irq, captures into reg 1 and halts
		wr(`SETM_A_CFG, 32'h1);
		wr(`SETM_A_CNT, 32'h0);
		wr(`SETM_A_MV, v);
		wr(`SETM_A_EV, 32'h1);
		wr(`SETM_A_EV + 12'h4, 32'h3400);
		wr(`SETM_A_OUTM, 32'h1);
		wr(`SETM_A_DMA, 32'h1);
		wr(`SETM_A_INTEN, 32'h1);
		wr(`SETM_A_MODE, 32'h2);
		wr(`SETM_A_CAP + 12'h4, 32'h1);
		wr(`SETM_A_HALT, 32'h1);
		rdm("match reg", `SETM_A_MV);
		rdm("event ctrl", `SETM_A_EV + 12'h4);
		// high halt left set: the unified count runs on the low bit alone
		wr(`SETM_A_CTRL, 32'h00020000);
		n = 0;
		while (dma_req[0] !== 1'b1 && n < 2000)
		begin
			@(posedge pclk);
			n++;
		end
		if (n >= 2000)
			failures++;
		chk("dma req", 32'h1, {31'h0, dma_req[0]});
		chk("out set", 32'h1, {31'h0, out_pins[0]});
		chk("irq", 32'h1, {31'h0, irq});
		@(posedge pclk);
		chk("dma pulse", 32'h0, {31'h0, dma_req[0]});
		apb(1'b0, `SETM_A_STATE, 32'h0);
		chk("state", 32'h1, rd);
		apb(1'b0, `SETM_A_FLAG, 32'h0);
		chk("flag", 32'h1, rd);
		apb(1'b0, `SETM_A_MV + 12'h4, 32'h0);
		chk("capture", v, rd);
		// count frozen one past the match while halted
		repeat (2)
		begin
			apb(1'b0, `SETM_A_CNT, 32'h0);
			chk("halted count", v + 32'h1, rd);
			repeat (20) @(posedge pclk);
		end
		apb(1'b0, `SETM_A_CTRL, 32'h0);
		chk("halt held", 32'h00020002, rd);
		wr(`SETM_A_FLAG, 32'h1);
		@(posedge pclk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		// state 1 leaves event 0 disabled as the count passes the match again
		wr(`SETM_A_CNT, 32'h0);
		wr(`SETM_A_CTRL, 32'h00020000);
		repeat (100) @(posedge pclk);
		apb(1'b0, `SETM_A_FLAG, 32'h0);
		chk("gated flag", 32'h0, rd);
		// running counter refuses a config write
		apb(1'b1, `SETM_A_CFG, 32'h0);
		chk("busy cfg err", 32'h1, {31'h0, err});
		rdm("cfg kept", `SETM_A_CFG);
		apb(1'b0, `SETM_A_ERR, 32'h0);
		chk("err flag", 32'h1, rd);
		// event 1 limits, stops, toggles out 0, clears out 1; event 2 restarts on out 1
		wr(`SETM_A_CTRL, 32'h00020002);
		wr(`SETM_A_CNT, 32'h0);
		wr(`SETM_A_MV + 12'h8, v);
		wr(`SETM_A_EV + 12'h8, 32'h2);
		wr(`SETM_A_EV + 12'hc, 32'h0402);
		wr(`SETM_A_EV + 12'h10, 32'h2);
		wr(`SETM_A_EV + 12'h14, 32'h0b90);
		wr(`SETM_A_OUTM, 32'h3);
		wr(`SETM_A_OUTM + 12'h4, 32'h2);
		wr(`SETM_A_OUTM + 12'hc, 32'h2);
		wr(`SETM_A_RES, 32'h3);
		wr(`SETM_A_LIM, 32'h2);
		wr(`SETM_A_STOP, 32'h2);
		wr(`SETM_A_START, 32'h4);
		wr(`SETM_A_CTRL, 32'h00020000);
		repeat (100) @(posedge pclk);
		apb(1'b0, `SETM_A_CNT, 32'h0);
		chk("limit count", 32'h0, rd);
		apb(1'b0, `SETM_A_CTRL, 32'h0);
		chk("stopped", 32'h00020001, rd);
		chk("toggle low", 32'h0, {30'h0, out_pins[1:0]});
		// output 1 high restarts the count until event 1 clears it
		wr(`SETM_A_OUTPUT, 32'h2);
		apb(1'b0, `SETM_A_CTRL, 32'h0);
		chk("started", 32'h00020000, rd);
		repeat (100) @(posedge pclk);
		apb(1'b0, `SETM_A_CTRL, 32'h0);
		chk("stop beats start", 32'h00020001, rd);
		chk("toggle and clear", 32'h1, {30'h0, out_pins[1:0]});
		apb(1'b0, `SETM_A_FLAG, 32'h0);
		chk("event flags", 32'h6, rd);
		chk("irq masked", 32'h0, {31'h0, irq});
		print_verdict();
	end
endmodule // setm_top_tb
